// ==== hdl/hspm_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - halt opcode enters halt state
// - halt keeps clock, dma running; refresh runs while no bus grant
// - halt indicator low while halted
// - halted core dummy fetches, executes none
// - reset low six cycles restarts at zero
// - unmasked interrupt ends halt; masked ignored
// - nmi ends halt regardless of global enable
// - two-byte sleep instruction enters sleep
// - sleep stops core clock, refresh, dma
// - sleep still grants bus requests
// - sleep: address high, controls high, data off
// - reset low six cycles ends sleep
// - sleep wakes on nmi, ext_int_line_zero/2, serial, timer
// - nmi in sleep starts nmi response
// - disabled source leaves device asleep
// - enabled source, global on: interrupt response
// - enabled source, global off: resume after sleep
// - peripheral stop bit halts serial and timer
// - stop bit plus sleep gives system stop
module hspm_ctrl
  import hspm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  input wire logic [7:0] opcode,
  input wire logic opcode_valid,
  input wire hspm_pkg::hspm_irq_t irq_req,
  input wire hspm_pkg::hspm_irq_t irq_en,
  input wire logic bus_request_in_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic halt_b,
  output logic bus_grant_out_b,
  output hspm_pkg::hspm_bus_t bus_out,
  output logic core_clk_en,
  output logic refresh_cycle_en,
  output logic dma_controller_en,
  output logic periph_run,
  output logic dummy_fetch,
  output logic exec_en,
  output logic core_restart,
  output logic [19:0] restart_addr,
  output hspm_pkg::hspm_wake_t wake_kind,
  output logic wake_pulse
);
  import hspm_pkg::*;
  hspm_mode_t mode_r;
  hspm_mode_t mode_nxt;
  hspm_wake_t wake_nxt;
  logic peripheral_stop_bit_r;
  logic global_int_enable_flag_r;
  logic sleep_pfx_r;
  logic reset_taken;
  logic nmi_d_r;
  logic nmi_edge;
  logic grant_r;
  logic maskable_hit;
  logic maskable_enabled;
  hspm_irq_t live_irq;

  // ----------------------------------------
  // reset pin qualifier
  // ----------------------------------------
  hspm_rst_filt u_rst_filt (
    .clock(clock),
    .rst_b(rst_b),
    .reset_pin_b(reset_pin_b),
    .reset_taken(reset_taken)
  );

  // ----------------------------------------
  // interrupt qualification
  // ----------------------------------------
  function automatic hspm_irq_t mask_stopped(input hspm_irq_t req, input logic pstop);
    hspm_irq_t r;
    r = req;
    if (pstop) begin
      r.serial = 1'b0;
      r.timer = 1'b0;
    end
    return r;
  endfunction

  always_comb begin
    live_irq = mask_stopped(irq_req, peripheral_stop_bit_r);
    maskable_enabled = (live_irq.ext_int_line_zero && irq_en.ext_int_line_zero)
      || (live_irq.ext_int_line_two && irq_en.ext_int_line_two)
      || (live_irq.serial && irq_en.serial)
      || (live_irq.timer && irq_en.timer);
    maskable_hit = maskable_enabled && global_int_enable_flag_r;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nmi_d_r <= 1'b0;
    end else begin
      nmi_d_r <= irq_req.nmi;
    end
  end
  assign nmi_edge = irq_req.nmi && !nmi_d_r;

  // ----------------------------------------
  // mode sequencing
  // ----------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    wake_nxt = HSPM_WAKE_NONE;
    unique case (mode_r)
      HSPM_RUN: begin
        if (opcode_valid && !sleep_pfx_r && opcode == HSPM_OP_HALT) begin
          mode_nxt = HSPM_HALT;
        end else if (opcode_valid && sleep_pfx_r && opcode == HSPM_OP_SLEEP_SFX) begin
          mode_nxt = HSPM_SLEEP;
        end
      end
      HSPM_HALT: begin
        if (nmi_edge) begin
          mode_nxt = HSPM_RUN;
          wake_nxt = HSPM_WAKE_NMI;
        end else if (maskable_hit) begin
          mode_nxt = HSPM_RUN;
          wake_nxt = HSPM_WAKE_RESP;
        end
      end
      HSPM_SLEEP: begin
        if (nmi_edge) begin
          mode_nxt = HSPM_RUN;
          wake_nxt = HSPM_WAKE_NMI;
        end else if (maskable_hit) begin
          mode_nxt = HSPM_RUN;
          wake_nxt = HSPM_WAKE_RESP;
        end else if (maskable_enabled) begin
          mode_nxt = HSPM_RUN;
          wake_nxt = HSPM_WAKE_RESUME;
        end
      end
    endcase
    if (reset_taken) begin
      mode_nxt = HSPM_RUN;
      wake_nxt = HSPM_WAKE_NONE;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= HSPM_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleep_pfx_r <= 1'b0;
    end else if (mode_r != HSPM_RUN || reset_taken) begin
      sleep_pfx_r <= 1'b0;
    end else if (opcode_valid) begin
      sleep_pfx_r <= !sleep_pfx_r && (opcode == HSPM_OP_SLEEP_PFX);
    end
  end

  // ----------------------------------------
  // wake and restart reporting
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wake_kind <= HSPM_WAKE_NONE;
      wake_pulse <= 1'b0;
      core_restart <= 1'b0;
      restart_addr <= HSPM_RESET_VECTOR;
    end else begin
      wake_kind <= wake_nxt;
      wake_pulse <= (wake_nxt != HSPM_WAKE_NONE);
      core_restart <= reset_taken;
      restart_addr <= HSPM_RESET_VECTOR;
    end
  end

  // ----------------------------------------
  // clock and unit enables
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      core_clk_en <= 1'b1;
      refresh_cycle_en <= 1'b1;
      dma_controller_en <= 1'b1;
      periph_run <= 1'b1;
    end else begin
      // registered from next mode so restart lands on a whole cycle
      core_clk_en <= (mode_nxt != HSPM_SLEEP);
      refresh_cycle_en <= (mode_nxt != HSPM_SLEEP) && !grant_r;
      dma_controller_en <= (mode_nxt != HSPM_SLEEP);
      periph_run <= !peripheral_stop_bit_r;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      halt_b <= 1'b1;
      dummy_fetch <= 1'b0;
      exec_en <= 1'b1;
    end else begin
      halt_b <= (mode_nxt != HSPM_HALT);
      dummy_fetch <= (mode_nxt == HSPM_HALT);
      exec_en <= (mode_nxt == HSPM_RUN);
    end
  end

  // ----------------------------------------
  // bus exchange and pin levels
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      grant_r <= 1'b0;
      bus_grant_out_b <= 1'b1;
    end else begin
      grant_r <= !bus_request_in_b;
      bus_grant_out_b <= bus_request_in_b;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_out <= '{addr: HSPM_ADDR_IDLE, ctrl_n: 1'b1, data_oe_b: 1'b1};
    end else if (mode_nxt == HSPM_SLEEP) begin
      bus_out <= '{addr: HSPM_ADDR_IDLE, ctrl_n: 1'b1, data_oe_b: 1'b1};
    end else begin
      bus_out <= '{addr: HSPM_ADDR_IDLE, ctrl_n: 1'b1, data_oe_b: 1'b1};
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      peripheral_stop_bit_r <= HSPM_CTRL_RST[HSPM_CTRL_PSTOP_BIT];
      global_int_enable_flag_r <= HSPM_CTRL_RST[HSPM_CTRL_GIE_BIT];
    end else if (reset_taken) begin
      peripheral_stop_bit_r <= HSPM_CTRL_RST[HSPM_CTRL_PSTOP_BIT];
      global_int_enable_flag_r <= HSPM_CTRL_RST[HSPM_CTRL_GIE_BIT];
    end else if (reg_wr && reg_addr == HSPM_ADDR_CTRL) begin
      peripheral_stop_bit_r <= reg_wdata[HSPM_CTRL_PSTOP_BIT];
      global_int_enable_flag_r <= reg_wdata[HSPM_CTRL_GIE_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        HSPM_ADDR_CTRL: reg_rdata <= {6'h00, global_int_enable_flag_r, peripheral_stop_bit_r};
        HSPM_ADDR_STAT: reg_rdata <= {6'h00, mode_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_halt_entry: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == HSPM_RUN && opcode_valid && !sleep_pfx_r && opcode == HSPM_OP_HALT && !reset_taken)
    |=> !halt_b) else $error("halt not shown");
  a_halt_pin: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == HSPM_HALT) |-> !halt_b) else $error("halt pin high while halted");
  a_halt_noexec: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == HSPM_HALT) |-> (dummy_fetch && !exec_en)) else $error("halted core executing");
  a_reset_exit: assert property (@(posedge clock) disable iff (!rst_b)
    (!reset_pin_b)[*7] |=> (mode_r == HSPM_RUN)) else $error("reset did not exit");
  a_nmi_wake: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r != HSPM_RUN && nmi_edge && !reset_taken) |=> (wake_kind == HSPM_WAKE_NMI && wake_pulse))
    else $error("nmi wake missed");
  a_halt_masked: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == HSPM_HALT && !nmi_edge && !maskable_hit && !reset_taken) |=> (mode_r == HSPM_HALT))
    else $error("masked interrupt left halt");
  a_sleep_clk: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == HSPM_SLEEP) |-> (!core_clk_en && !refresh_cycle_en && !dma_controller_en))
    else $error("sleep clocks running");
  a_sleep_resume: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == HSPM_SLEEP && !nmi_edge && maskable_enabled && !global_int_enable_flag_r && !reset_taken)
    |=> (wake_kind == HSPM_WAKE_RESUME && core_clk_en)) else $error("resume wake wrong");
  a_sleep_ignore: assert property (@(posedge clock) disable iff (!rst_b)
    (mode_r == HSPM_SLEEP && !nmi_edge && !maskable_enabled && !reset_taken) |=> (mode_r == HSPM_SLEEP))
    else $error("disabled source woke sleep");
  a_pstop_run: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(peripheral_stop_bit_r) |=> !periph_run) else $error("peripherals not stopped");
  a_grant: assert property (@(posedge clock) disable iff (!rst_b)
    (!bus_request_in_b) |=> !bus_grant_out_b) else $error("bus request not granted");
endmodule

// ==== include/hspm_pkg.sv ====
package hspm_pkg;
  // ----------------------------------------
  // instruction codes
  // ----------------------------------------
  localparam logic [7:0] HSPM_OP_HALT = 8'h76;
  localparam logic [7:0] HSPM_OP_SLEEP_PFX = 8'hed;
  localparam logic [7:0] HSPM_OP_SLEEP_SFX = 8'h76;
  // ----------------------------------------
  // reset and restart
  // ----------------------------------------
  localparam int HSPM_RESET_MIN_CYCLES = 6;
  localparam logic [2:0] HSPM_RESET_CNT_MAX = 3'(HSPM_RESET_MIN_CYCLES);
  localparam logic [19:0] HSPM_RESET_VECTOR = 20'h00000;
  localparam logic [19:0] HSPM_ADDR_IDLE = 20'hfffff;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] HSPM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] HSPM_ADDR_STAT = 8'h04;
  localparam int HSPM_CTRL_PSTOP_BIT = 0;
  localparam int HSPM_CTRL_GIE_BIT = 1;
  localparam logic [7:0] HSPM_CTRL_RST = 8'h00;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {HSPM_RUN, HSPM_HALT, HSPM_SLEEP} hspm_mode_t;
  typedef enum logic [1:0] {HSPM_WAKE_NONE, HSPM_WAKE_RESP, HSPM_WAKE_RESUME, HSPM_WAKE_NMI} hspm_wake_t;
  typedef struct packed {
    logic nmi;
    logic ext_int_line_zero;
    logic ext_int_line_two;
    logic serial;
    logic timer;
  } hspm_irq_t;
  typedef struct packed {
    logic [19:0] addr;
    logic ctrl_n;
    logic data_oe_b;
  } hspm_bus_t;
endpackage

// ==== hdl/hspm_rst_filt.sv ====
`timescale 1ns/1ps
module hspm_rst_filt
  import hspm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reset_pin_b,
  output logic reset_taken
);
  import hspm_pkg::*;
  logic [2:0] low_cnt_r;
  // ----------------------------------------
  // count low cycles of the reset pin
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_r <= 3'h0;
    end else if (reset_pin_b) begin
      low_cnt_r <= 3'h0;
    end else if (low_cnt_r != HSPM_RESET_CNT_MAX) begin
      low_cnt_r <= low_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reset_taken <= 1'b0;
    end else begin
      reset_taken <= !reset_pin_b && (low_cnt_r == HSPM_RESET_CNT_MAX - 3'h1);
    end
  end
endmodule

// ==== sim/hspm_partner.sv ====
`timescale 1ns/1ps
module hspm_partner (
  input wire logic clock,
  output hspm_pkg::hspm_irq_t irq_req,
  output logic bus_request_in_b,
  output logic reset_pin_b
);
  import hspm_pkg::*;
  initial begin
    irq_req = '0;
    bus_request_in_b = 1'b1;
    reset_pin_b = 1'b1;
  end
  // ----------------------------------------
  // interrupt sources: levels held until dropped
  // ----------------------------------------
  task automatic raise(input hspm_irq_t src);
    @(posedge clock);
    irq_req <= irq_req | src;
  endtask
  task automatic drop(input hspm_irq_t src);
    @(posedge clock);
    irq_req <= irq_req & ~src;
  endtask
  // ----------------------------------------
  // alternate master and reset source
  // ----------------------------------------
  task automatic bus_req(input logic on);
    @(posedge clock);
    bus_request_in_b <= ~on;
  endtask
  task automatic hold_reset(input int n);
    @(posedge clock);
    reset_pin_b <= 1'b0;
    repeat (n) @(posedge clock);
    reset_pin_b <= 1'b1;
  endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  import hspm_pkg::*;
  logic clock;
  logic rst_b;
  logic [7:0] opcode;
  logic opcode_valid;
  hspm_irq_t irq_en;
  hspm_irq_t irq_req;
  logic bus_request_in_b, reset_pin_b, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic halt_b, bus_grant_out_b, core_clk_en, refresh_cycle_en, dma_controller_en;
  logic periph_run, dummy_fetch, exec_en, core_restart, wake_pulse;
  logic [19:0] restart_addr;
  hspm_bus_t bus_out;
  hspm_wake_t wake_kind;
  int fails = 0, checked = 0, cycles = 0;
  hspm_ctrl hspm_ctrl_i (.clock(clock), .rst_b(rst_b), .reset_pin_b(reset_pin_b), .opcode(opcode),
    .opcode_valid(opcode_valid), .irq_req(irq_req), .irq_en(irq_en), .bus_request_in_b(bus_request_in_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_b(halt_b), .bus_grant_out_b(bus_grant_out_b), .bus_out(bus_out), .core_clk_en(core_clk_en),
    .refresh_cycle_en(refresh_cycle_en), .dma_controller_en(dma_controller_en), .periph_run(periph_run),
    .dummy_fetch(dummy_fetch), .exec_en(exec_en), .core_restart(core_restart),
    .restart_addr(restart_addr), .wake_kind(wake_kind), .wake_pulse(wake_pulse));
  hspm_partner hspm_partner_i (.clock(clock), .irq_req(irq_req), .bus_request_in_b(bus_request_in_b),
    .reset_pin_b(reset_pin_b));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ----------------------------------------
  // run closing and hang guard
  // ----------------------------------------
  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", ex, reg_rdata);
  endtask
  task automatic ops(input logic [15:0] seq, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clock);
      opcode <= seq[8*i +: 8];
      opcode_valid <= 1'b1;
    end
    @(posedge clock);
    opcode_valid <= 1'b0;
    tick(2);
  endtask
  // waits for a wake or restart pulse, bounded
  task automatic wait_pulse(input bit for_wake, input hspm_wake_t ex);
    int k;
    k = 0;
    while (k < 20 && ((for_wake ? wake_pulse : core_restart) !== 1'b1)) begin
      tick(1);
      k++;
    end
    `CHK("pulse", 1'b1, for_wake ? wake_pulse : core_restart);
    if (for_wake) begin
      `CHK("wake_kind", ex, wake_kind);
    end
  endtask
  localparam logic [15:0] SLEEP_INSTRUCTION = {HSPM_OP_SLEEP_PFX, HSPM_OP_SLEEP_SFX};
  localparam logic [15:0] HLT = {8'h00, HSPM_OP_HALT};
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst_b <= 1'b0;
    opcode <= 8'h00;
    opcode_valid <= 1'b0;
    irq_en <= '0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= 8'h00;
    reg_wdata <= 8'h00;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd_chk(HSPM_ADDR_CTRL, HSPM_CTRL_RST);
    rd_chk(HSPM_ADDR_STAT, 8'h00);
    rd_chk(8'h10, 8'h00);
    `CHK("exec_en", 1'b1, exec_en);
    $display("test reset done");
    @(posedge clock);
    irq_en <= '1;
    ops(HLT, 1);
    `CHK("halt_b", 1'b0, halt_b);
    `CHK("dummy_fetch", 2'b10, {dummy_fetch, exec_en});
    `CHK("run_en", 3'b111, {core_clk_en, refresh_cycle_en, dma_controller_en});
    rd_chk(HSPM_ADDR_STAT, 8'h01);
    hspm_partner_i.bus_req(1'b1);
    tick(2);
    `CHK("grant", 1'b0, bus_grant_out_b);
    hspm_partner_i.bus_req(1'b0);
    hspm_partner_i.raise(5'h08);
    tick(4);
    `CHK("halt_b", 1'b0, halt_b);
    hspm_partner_i.raise(5'h10);
    wait_pulse(1'b1, HSPM_WAKE_NMI);
    hspm_partner_i.drop(5'h18);
    ops(HLT, 1);
    wr(HSPM_ADDR_CTRL, 8'h02);
    hspm_partner_i.raise(5'h08);
    wait_pulse(1'b1, HSPM_WAKE_RESP);
    hspm_partner_i.drop(5'h08);
    tick(1);
    `CHK("halt_b", 1'b1, halt_b);
    $display("test halt done");
    for (int i = 0; i < 4; i++) begin
      ops(SLEEP_INSTRUCTION, 2);
      rd_chk(HSPM_ADDR_STAT, 8'h02);
      `CHK("stop_en", 4'b0001, {core_clk_en, refresh_cycle_en, dma_controller_en, periph_run});
      `CHK("bus_out", {HSPM_ADDR_IDLE, 1'b1, 1'b1}, bus_out);
      hspm_partner_i.raise(hspm_irq_t'(5'h01 << i));
      wait_pulse(1'b1, HSPM_WAKE_RESP);
      `CHK("core_clk_en", 1'b1, core_clk_en);
      hspm_partner_i.drop(hspm_irq_t'(5'h01 << i));
    end
    wr(HSPM_ADDR_CTRL, 8'h00);
    irq_en <= 5'h1b;
    ops(SLEEP_INSTRUCTION, 2);
    hspm_partner_i.raise(5'h04);
    hspm_partner_i.bus_req(1'b1);
    tick(3);
    rd_chk(HSPM_ADDR_STAT, 8'h02);
    `CHK("grant", 1'b0, bus_grant_out_b);
    hspm_partner_i.bus_req(1'b0);
    irq_en <= '1;
    wait_pulse(1'b1, HSPM_WAKE_RESUME);
    hspm_partner_i.drop(5'h04);
    $display("test sleep done");
    wr(HSPM_ADDR_CTRL, 8'h01);
    tick(2);
    `CHK("periph_run", 2'b01, {periph_run, core_clk_en});
    ops(SLEEP_INSTRUCTION, 2);
    hspm_partner_i.raise(5'h03);
    tick(4);
    rd_chk(HSPM_ADDR_STAT, 8'h02);
    hspm_partner_i.raise(5'h10);
    wait_pulse(1'b1, HSPM_WAKE_NMI);
    hspm_partner_i.drop(5'h13);
    wr(HSPM_ADDR_CTRL, 8'h00);
    tick(2);
    `CHK("periph_run", 1'b1, periph_run);
    $display("test stop done");
    for (int m = 0; m < 2; m++) begin
      ops(m == 0 ? HLT : SLEEP_INSTRUCTION, m + 1);
      fork
        hspm_partner_i.hold_reset(HSPM_RESET_MIN_CYCLES + m);
        wait_pulse(1'b0, HSPM_WAKE_NONE);
      join
      `CHK("restart_addr", HSPM_RESET_VECTOR, restart_addr);
      tick(2);
      rd_chk(HSPM_ADDR_STAT, 8'h00);
    end
    $display("test restart done");
    stop_test();
  end
endmodule
